// ### hw/adcrc_consts.vh
// Constants for the converter register front end: offsets, fields,
// reset values and timing figures. Assumes inclusion by bare name.
`ifndef ADCRC_CONSTS_VH
`define ADCRC_CONSTS_VH
// Register addresses on the special function register bus
`define ADCRC_ADDR_FMT      8'hD1
`define ADCRC_ADDR_TIMING   8'hD2
`define ADCRC_ADDR_CHPWR    8'hD3
`define ADCRC_ADDR_RES_HI   8'hD4
`define ADCRC_ADDR_RES_LO   8'hD5
// Reset values
`define ADCRC_RESET_VAL     8'h00
// Channel/power register fields
`define ADCRC_PWR_BIT       7
`define ADCRC_BUSY_BIT      6
`define ADCRC_CHAN_MSB      5
`define ADCRC_CHAN_LSB      2
`define ADCRC_REF_MSB       1
`define ADCRC_REF_LSB       0
// Timing register fields
`define ADCRC_DIFF_MSB      7
`define ADCRC_DIFF_LSB      6
`define ADCRC_CONT_BIT      5
`define ADCRC_RATE_MSB      4
`define ADCRC_RATE_LSB      2
`define ADCRC_ACQ_MSB       1
`define ADCRC_ACQ_LSB       0
// Format/status register fields
`define ADCRC_RES_MSB       7
`define ADCRC_RES_LSB       6
`define ADCRC_JUST_BIT      5
`define ADCRC_UFLOW_BIT     4
`define ADCRC_OFLOW_BIT     3
`define ADCRC_RANGE_BIT     2
// Clock figures, MHz
`define ADCRC_MCLK_MHZ      125
`define ADCRC_CORE_MHZ      16
// Busy rises this many converter-clock cycles after the start write
`define ADCRC_BUSY_DLY_CORE 4
// Busy delay in mclk cycles, rounded up: ceil(4*125/16) = 32
`define ADCRC_BUSY_DLY_CYC  ((`ADCRC_BUSY_DLY_CORE*`ADCRC_MCLK_MHZ+`ADCRC_CORE_MHZ-1)/`ADCRC_CORE_MHZ)
// Sampling periods in microseconds for 2/4/8/16 ksps
`define ADCRC_PER_2K_US     500
`define ADCRC_PER_4K_US     250
`define ADCRC_PER_8K_US     125
`define ADCRC_PER_16K_US    63
// Power-down delays in microseconds
`define ADCRC_PDD_1_US      6
`define ADCRC_PDD_2_US      24
`endif

// ### hw/adcrc_tick.v
// Programmable interval timer that pulses once per loaded period.
// Assumes one clock and a synchronous active-high clear from the top.
`timescale 1ns/1ps
module adcrc_tick #(
  parameter W = 17 // Counter width
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  // Control
  input  wire         clear,
  input  wire         run,
  input  wire [W-1:0] period,
  // Result
  output reg          tick
);
  reg [W-1:0] cnt_r; // Cycles elapsed in current period
  // Increment step at full width, so no operand is padded
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////
  // Count up while run, pulse and wrap at period-1
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end
    else if (clear || !run)
    begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end
    else if (cnt_r + ONE >= period)
    begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + ONE;
      tick  <= 1'b0;
    end
  end
endmodule // adcrc_tick

// ### hw/adcrc_ctrl.v
// Register front end and sequencer for the successive-approximation
// converter. Assumes the core bus gives one-cycle read/write strobes
// on mclk, and the analog core answers a start with a done pulse.
//
// How it works
// - Power bit low powers down; high enables inputs
// - Busy reads one until result is loaded
// - Channel codes 0-13 external, 14/15 supply fractions
// - Reference codes: bandgap, supply, input 3, input 9
// - Input mode: single-ended or differential on 2/6
// - Conversion mode bit: single-step or continuous
// - Continuous rate codes give 2/4/8/16 ksps
// - Single-step rate codes 01/10 give power-down delay; 11 holds standby until next start
// - Acquisition code selects window length
// - Resolution and justification from format register
// - Result bytes hold justified result, zeros elsewhere
// - Underflow flag set on all-zero result
// - Overflow flag set on all-ones result
// - Range flag is overflow OR underflow
// - Channel/power write with power set starts or restarts conversion
// - Busy after four core cycles; interrupt at end
`timescale 1ns/1ps
`include "adcrc_consts.vh"
module adcrc_ctrl #(
  parameter BUSY_DLY = `ADCRC_BUSY_DLY_CYC, // Start-to-busy delay
  parameter PER_2K   = `ADCRC_PER_2K_US*`ADCRC_MCLK_MHZ,  // 2 ksps
  parameter PER_4K   = `ADCRC_PER_4K_US*`ADCRC_MCLK_MHZ,  // 4 ksps
  parameter PER_8K   = `ADCRC_PER_8K_US*`ADCRC_MCLK_MHZ,  // 8 ksps
  parameter PER_16K  = `ADCRC_PER_16K_US*`ADCRC_MCLK_MHZ, // 16 ksps
  parameter PDD_6US  = `ADCRC_PDD_1_US*`ADCRC_MCLK_MHZ,   // 6 us
  parameter PDD_24US = `ADCRC_PDD_2_US*`ADCRC_MCLK_MHZ    // 24 us
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // Special function register bus
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  output reg  [7:0]  sfr_rdata,
  // Analog core side
  output wire        core_power,
  output wire        core_standby,
  output wire        pins_analog,
  output wire [3:0]  channel_sel,
  output wire [1:0]  reference_sel,
  output wire [1:0]  input_mode,
  output wire [1:0]  acq_sel,
  output wire [1:0]  resolution_sel,
  output reg         core_start,
  input  wire        core_done,
  input  wire [11:0] conversion_result,
  // Interrupt to the processor
  output reg         conversion_done_interrupt
);
  ////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg rst_s1_r; // First release stage
  reg rst_n_r;  // Released reset for the design
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Done comes from the analog macro, so it is synchronised
  reg done_s1_r; // First stage, read only by the second
  reg done_s2_r; // Synchronised level
  reg done_s3_r; // Previous level for edge detect
  wire done_evt = done_s2_r & ~done_s3_r; // Rising edge of done

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0]  chpwr_r;   // Channel/power, busy bit kept separately
  reg [7:0]  timing_r;  // Timing control
  reg [2:0]  fmt_r;     // Resolution and justify
  reg [2:0]  flags_r;   // Underflow, overflow, range
  reg [11:0] data_r;    // Captured conversion result
  reg        busy_r;    // Conversion in progress flag
  reg        active_r;  // Sequence running (before and during busy)
  reg [5:0]  dly_r;     // Start-to-busy counter
  reg        standby_r; // Core held in standby after conversion

  wire wr_chpwr  = sfr_wr && (sfr_addr == `ADCRC_ADDR_CHPWR);
  wire wr_timing = sfr_wr && (sfr_addr == `ADCRC_ADDR_TIMING);
  wire wr_fmt    = sfr_wr && (sfr_addr == `ADCRC_ADDR_FMT);
  wire pwr       = chpwr_r[`ADCRC_PWR_BIT];
  wire cont      = timing_r[`ADCRC_CONT_BIT];
  wire [2:0] rate = timing_r[`ADCRC_RATE_MSB:`ADCRC_RATE_LSB];
  wire cont_tick; // Continuous-mode pacing pulse
  wire pdd_tick;  // Power-down delay expiry

  // A write with power set, or a pacing tick, launches a conversion
  wire start = (wr_chpwr && sfr_wdata[`ADCRC_PWR_BIT])
               || (pwr && cont && cont_tick);

  ////////////////////////////////////////////////////////////////////
  // Configuration writes; read-only bits are never written
  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      chpwr_r  <= `ADCRC_RESET_VAL;
      timing_r <= `ADCRC_RESET_VAL;
      fmt_r    <= 3'h0;
    end
    else
    begin
      if (wr_chpwr)
        chpwr_r <= sfr_wdata & 8'hBF;
      if (wr_timing)
        timing_r <= sfr_wdata;
      if (wr_fmt)
        fmt_r <= sfr_wdata[7:5];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result masking by resolution and flag detection
  reg [11:0] res_mask; // Valid bits of the result
  always @*
  begin
    case (fmt_r[2:1])
      2'b00:   res_mask = 12'h03F;
      2'b01:   res_mask = 12'h0FF;
      2'b10:   res_mask = 12'h3FF;
      default: res_mask = 12'hFFF;
    endcase
  end
  wire [11:0] res_v    = conversion_result & res_mask;
  wire        res_zero = (res_v == 12'h000);
  wire        res_ones = (res_v == res_mask);

  ////////////////////////////////////////////////////////////////////
  // Conversion sequencer: delay, busy, capture, interrupt
  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      done_s1_r  <= 1'b0;
      done_s2_r  <= 1'b0;
      done_s3_r  <= 1'b0;
      active_r   <= 1'b0;
      busy_r     <= 1'b0;
      dly_r      <= 6'h00;
      core_start <= 1'b0;
      data_r     <= 12'h000;
      flags_r    <= 3'h0;
      conversion_done_interrupt <= 1'b0;
    end
    else
    begin
      done_s1_r  <= core_done;
      done_s2_r  <= done_s1_r;
      done_s3_r  <= done_s2_r;
      core_start <= 1'b0;
      conversion_done_interrupt <= 1'b0;
      if (start)
      begin
        // Abort any running conversion and begin again
        active_r <= 1'b1;
        busy_r   <= 1'b0;
        dly_r    <= 6'h00;
      end
      else if (wr_chpwr && !sfr_wdata[`ADCRC_PWR_BIT])
      begin
        // Powering down kills the sequence
        active_r <= 1'b0;
        busy_r   <= 1'b0;
      end
      else if (active_r && !busy_r)
      begin
        if (dly_r == BUSY_DLY[5:0] - 6'h01)
        begin
          busy_r     <= 1'b1;
          core_start <= 1'b1;
        end
        else
          dly_r <= dly_r + 6'h01;
      end
      else if (busy_r && done_evt)
      begin
        data_r   <= conversion_result;
        flags_r  <= {res_zero, res_ones, res_zero | res_ones};
        busy_r   <= 1'b0;
        active_r <= 1'b0;
        conversion_done_interrupt <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Justified 16-bit view of the captured result
  reg [15:0] just; // High byte : low byte
  always @*
  begin
    just = 16'h0000;
    case ({fmt_r[0], fmt_r[2:1]})
      3'b000:  just = {data_r[5:0], 10'h000};
      3'b001:  just = {data_r[7:0], 8'h00};
      3'b010:  just = {data_r[9:0], 6'h00};
      3'b011:  just = {data_r[11:0], 4'h0};
      3'b100:  just = {10'h000, data_r[5:0]};
      3'b101:  just = {8'h00, data_r[7:0]};
      3'b110:  just = {6'h00, data_r[9:0]};
      default: just = {4'h0, data_r[11:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always @*
  begin
    case (sfr_addr)
      `ADCRC_ADDR_CHPWR:
        sfr_rdata = {chpwr_r[7], busy_r, chpwr_r[5:0]};
      `ADCRC_ADDR_TIMING: sfr_rdata = timing_r;
      `ADCRC_ADDR_FMT:
        sfr_rdata = {fmt_r, flags_r[2:1], flags_r[0], 2'b00};
      `ADCRC_ADDR_RES_HI: sfr_rdata = just[15:8];
      `ADCRC_ADDR_RES_LO: sfr_rdata = just[7:0];
      default:            sfr_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Pacing period and power-down delay selection
  reg [16:0] cont_per; // Continuous sampling period in mclk cycles
  reg [16:0] pdd_per;  // Standby hold in mclk cycles
  always @*
  begin
    case (rate[1:0])
      2'b00:   cont_per = PER_2K[16:0];
      2'b01:   cont_per = PER_4K[16:0];
      2'b10:   cont_per = PER_8K[16:0];
      default: cont_per = PER_16K[16:0];
    endcase
    case (rate[1:0])
      2'b01:   pdd_per = PDD_6US[16:0];
      2'b10:   pdd_per = PDD_24US[16:0];
      default: pdd_per = 17'h00001;
    endcase
  end

  // Reserved codes 1XX leave continuous pacing off
  adcrc_tick #(.W(17)) u_rate (
    .mclk   (mclk),
    .rst_n  (rst_n_r),
    .clear  (wr_chpwr | wr_timing),
    .run    (pwr & cont & ~rate[2]),
    .period (cont_per),
    .tick   (cont_tick)
  );

  // Standby after single-step end for codes 01/10, then full power-down; code 11 holds standby
  adcrc_tick #(.W(17)) u_pdd (
    .mclk   (mclk),
    .rst_n  (rst_n_r),
    .clear  (start),
    .run    (standby_r & (rate[1:0] != 2'b11) & (rate[1:0] != 2'b00)),
    .period (pdd_per),
    .tick   (pdd_tick)
  );

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      standby_r <= 1'b0;
    else if (start || !pwr || cont)
      standby_r <= 1'b0;
    else if (conversion_done_interrupt && !rate[2] && rate[1:0] != 2'b00)
      standby_r <= 1'b1;
    else if (pdd_tick)
      standby_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Core controls
  assign core_power     = pwr & active_r;
  assign core_standby   = standby_r;
  assign pins_analog    = pwr;
  assign channel_sel    = chpwr_r[5:2];
  assign reference_sel  = chpwr_r[1:0];
  assign input_mode     = timing_r[7:6];
  assign acq_sel        = timing_r[1:0];
  assign resolution_sel = fmt_r[2:1];
endmodule // adcrc_ctrl

// ### tb/adcrc_asserts.sv
// Checker for the converter register front end.
// Assumes it is bound onto adcrc_ctrl and sees its ports only.
`timescale 1ns/1ps
module adcrc_asserts (
  // Clock and reset
  input wire       mclk,
  input wire       reset_n,
  // Register bus
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_wr,
  input wire [7:0] sfr_rdata,
  // Core side
  input wire       pins_analog,
  input wire [3:0] channel_sel,
  input wire [1:0] reference_sel,
  input wire [1:0] input_mode,
  input wire [1:0] acq_sel,
  input wire [1:0] resolution_sel,
  input wire       core_start,
  input wire       core_done,
  input wire       conversion_done_interrupt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Write decodes
  wire w1 = sfr_wr && sfr_addr == 8'hD1;
  wire w2 = sfr_wr && sfr_addr == 8'hD2;
  wire w3 = sfr_wr && sfr_addr == 8'hD3;
  a_start_late: assert property (
    w3 && sfr_wdata[7] |=> !core_start [*8]) else $error("start early");
  a_pins_power: assert property (
    w3 |=> pins_analog == $past(sfr_wdata[7])) else $error("pins");
  a_chan_ref: assert property (
    w3 |=> channel_sel == $past(sfr_wdata[5:2])
      && reference_sel == $past(sfr_wdata[1:0])) else $error("chan");
  a_timing_flds: assert property (
    w2 |=> input_mode == $past(sfr_wdata[7:6])
      && acq_sel == $past(sfr_wdata[1:0])) else $error("timing");
  a_res_fld: assert property (
    w1 |=> resolution_sel == $past(sfr_wdata[7:6])) else $error("resol");
  a_start_pulse: assert property (
    core_start |=> !core_start) else $error("start width");
  a_done_irq: assert property (
    $rose(core_done) |-> ##[1:4] conversion_done_interrupt)
    else $error("no interrupt");
  a_irq_pulse: assert property (
    conversion_done_interrupt |=> !conversion_done_interrupt)
    else $error("irq width");
  a_unmapped_zero: assert property (
    sfr_addr < 8'hD1 || sfr_addr > 8'hD5 |-> sfr_rdata == 8'h00)
    else $error("unmapped");
  a_range_or: assert property (
    sfr_addr == 8'hD1 |-> sfr_rdata[2] == (sfr_rdata[3] | sfr_rdata[4])
      && sfr_rdata[1:0] == 2'h0) else $error("range");
  c_start: cover property (w3 && sfr_wdata[7]);
  c_irq: cover property (conversion_done_interrupt);
  c_cont: cover property (w2 && sfr_wdata[5]);
endmodule // adcrc_asserts
bind adcrc_ctrl adcrc_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rdata(sfr_rdata), .pins_analog(pins_analog),
  .channel_sel(channel_sel), .reference_sel(reference_sel),
  .input_mode(input_mode), .acq_sel(acq_sel),
  .resolution_sel(resolution_sel), .core_start(core_start),
  .core_done(core_done),
  .conversion_done_interrupt(conversion_done_interrupt));

// ### tb/adcrc_core_model.sv
// Behavioural analog core: answers a start pulse with a done level.
// Assumes start is a one-cycle pulse on mclk.
`timescale 1ns/1ps
module adcrc_core_model (
  // Clock
  input wire        mclk,
  // Control from the front end
  input wire        start,
  input wire [11:0] value,
  input wire [7:0]  lat,
  // Answer
  output reg        done,
  output reg [11:0] result
);
  // Starts during a running answer are dropped, like a busy core
  initial
  begin
    done = 1'b0;
    result = 12'hFFF;
    forever
    begin
      @(posedge mclk);
      if (start === 1'b1)
      begin
        repeat (lat) @(posedge mclk);
        #1 result = value;
        done = 1'b1;
        repeat (6) @(posedge mclk);
        // Stale data is inverted so a late sample shows
        #1 done = 1'b0;
        result = ~value;
      end
    end
  end
endmodule // adcrc_core_model

// ### tb/tb.sv
// Self-checking bench for adcrc_ctrl with a behavioural core.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module tb;
  reg         mclk, reset_n, sfr_wr, sfr_rd;
  reg  [7:0]  sfr_addr, sfr_wdata, v, d;
  reg  [11:0] value;
  reg  [7:0]  lat;
  reg  [31:0] seed;
  reg  [15:0] n_irq, t, e;
  reg  [1:0]  res, rc;
  reg         just;
  wire [7:0]  sfr_rdata;
  wire        core_start, core_done, irq;
  wire        core_power, core_standby;
  wire [11:0] result;
  integer     failures, n_checks, i, k;
  // Short pacing periods keep the run brief; 2 ksps is never paced
  adcrc_ctrl #(.PER_4K(400), .PER_8K(400),
    .PER_16K(400), .PDD_6US(50), .PDD_24US(100)) dut (
    .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .core_power(core_power),
    .core_standby(core_standby),
    .pins_analog(), .channel_sel(), .reference_sel(), .input_mode(),
    .acq_sel(), .resolution_sel(), .core_start(core_start),
    .core_done(core_done), .conversion_result(result),
    .conversion_done_interrupt(irq));
  adcrc_core_model core (.mclk(mclk), .start(core_start),
    .value(value), .lat(lat), .done(core_done), .result(result));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Interrupt pulses counted
  always @(posedge mclk)
    if (irq === 1'b1) n_irq <= n_irq + 16'h1;
  function [31:0] xs(input [31:0] s);
  begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  end
  endfunction
  // Mask to resolution, then justify in a 16-bit pair
  function [15:0] jdata(input [1:0] r, input j, input [11:0] x);
    reg [15:0] m;
  begin
    m = {4'h0, x} & ((16'h1 << (6 + 2 * r)) - 16'h1);
    jdata = j ? m : m << (10 - 2 * r);
  end
  endfunction
  function [2:0] flags(input [1:0] r, input [11:0] x);
    reg [15:0] m, f;
  begin
    f = (16'h1 << (6 + 2 * r)) - 16'h1;
    m = {4'h0, x} & f;
    flags = {m == 16'h0, m == f, m == 16'h0 || m == f};
  end
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task close_out;
  begin
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // One-cycle write strobe, inputs moved 1 ns after the edge
  task wr(input [7:0] a, input [7:0] w);
  begin
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1 sfr_wr = 1'b0;
  end
  endtask
  // Address set after an edge, data taken at the next rising edge
  task rd(input [7:0] a);
  begin
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    v = sfr_rdata;
    sfr_rd <= 1'b0;
  end
  endtask
  task wait_irq;
  begin
    for (k = 0; k < 400 && n_irq == t; k = k + 1) @(posedge mclk);
  end
  endtask
  initial
  begin
    #400000;
    failures = failures + 1;
    close_out;
  end
  initial
  begin
    {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 0;
    {value, n_irq, failures, n_checks} = 0;
    lat = 8'd20;
    seed = 32'd66249;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 7; i = i + 1)
    begin
      rd(8'hD0 + i);
      check(v, 16'h0);
    end
    seed = xs(seed);
    wr(8'hD4, seed[7:0]);
    wr(8'hD5, seed[15:8]);
    wr(8'hD1, seed[23:16] | 8'h1F);
    rd(8'hD1);
    check(v, seed[23:16] & 8'hE0);
    rd(8'hD4);
    check(v, 16'h0);
    d = {1'b0, seed[30], 2'b00, seed[27:24]};
    rc = seed[27:26];
    wr(8'hD2, d);
    rd(8'hD2);
    check(v, d);
    for (i = 0; i < 12; i = i + 1)
    begin
      seed = xs(seed);
      res = i[1:0];
      just = i[2];
      value = i == 0 ? 12'h000 : i == 1 ? 12'hFFF : seed[11:0];
      lat = 8'd20 + seed[15:12];
      d = {1'b1, seed[22], seed[19:16], seed[21:20]};
      wr(8'hD1, {res, just, 5'h1F});
      t = n_irq;
      wr(8'hD3, d);
      rd(8'hD3);
      check(v, d & 8'hBF);
      repeat (40) @(posedge mclk);
      rd(8'hD3);
      check(v[6], 1'b1);
      check(core_power, 1'b1);
      wait_irq;
      check(n_irq, t + 16'h1);
      check(core_standby, rc != 2'b00);
      rd(8'hD3);
      check(v[6], 1'b0);
      rd(8'hD4);
      e[15:8] = v;
      rd(8'hD5);
      e[7:0] = v;
      check(e, jdata(res, just, value));
      rd(8'hD1);
      check(v, {res, just, flags(res, value), 2'b00});
    end
    // Restart in mid-sequence yields one result only
    t = n_irq;
    wr(8'hD3, 8'h80);
    wr(8'hD3, 8'h80);
    wait_irq;
    repeat (150) @(posedge mclk);
    check(n_irq, t + 16'h1);
    // Other registers written while powered must not start
    t = n_irq;
    wr(8'hD2, 8'h00);
    wr(8'hD1, 8'h00);
    repeat (150) @(posedge mclk);
    check(n_irq, t);
    // Power cleared before busy aborts with no result
    wr(8'hD3, 8'h80);
    wr(8'hD3, 8'h3C);
    repeat (150) @(posedge mclk);
    check(n_irq, t);
    check(core_power, 1'b0);
    // Continuous pacing: start write plus ticks at 400 and 800
    wr(8'hD2, 8'h2C);
    t = n_irq;
    wr(8'hD3, 8'h80);
    repeat (1000) @(posedge mclk);
    check(n_irq - t, 16'h3);
    wr(8'hD3, 8'h00);
    // Reset after power-down clears every register again
    repeat (100) @(posedge mclk);
    #1 reset_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    for (i = 1; i < 6; i = i + 1)
    begin
      rd(8'hD0 + i);
      check(v, 16'h0);
    end
    close_out;
  end
endmodule // tb
